// file: verilog/clm_monitor.sv
// Per-channel lock monitor: idle power-down, lock-loss confirmation,
// frequency delta tolerance scaling and ppm error capture.
// Assumes a simple register port on clk_sys and a ppm tally in the same domain.
// Function
// - With inhibit clear, power down channel 100ms after signal detect falls.
// - After a failed check, repeat it confirm-count times before declaring loss.
// - Lock regained during confirmation keeps lock high, counter back to zero.
// - Scale field picks base, base+[3:1], twice base, or twice base+[3:1].
// - Capture bit takes ppm error from tally, clears itself when done.
// - Ready flag set when a ppm error count can be read.
`timescale 1ns/100ps
`include "clm_defs.svh"

module clm_monitor
    import clm_pkg::*;
#(
    parameter int PD_CYCLES = `CLM_PD_CYCLES
)
(
    input  wire logic       clk_sys,        // Core clock, 125 MHz.
    input  wire logic       rstn,           // Asynchronous reset, active low.
    input  wire logic       reg_wr,         // Register write strobe.
    input  wire logic       reg_rd,         // Register read strobe.
    input  wire logic [7:0] reg_addr,       // Register offset.
    input  wire logic [7:0] reg_wdata,      // Register write data.
    output logic      [7:0] reg_rdata,      // Read data, valid cycle after reg_rd.
    input  wire logic       sig_det,        // Signal detect, asynchronous.
    input  wire logic       lock_crit,      // Lock criteria met, asynchronous.
    input  wire logic [7:0] ppm_delta_base, // Base frequency delta limit.
    output logic      [8:0] ppm_delta_eff,  // Scaled frequency delta limit.
    input  wire logic [15:0] ppm_count,     // Frequency offset tally.
    input  wire logic       ppm_count_vld,  // Tally result pulse.
    input  wire logic       ppm_res_read,   // Result pair read by software.
    output clm_ppm_res_t    ppm_res,        // Held ppm result and ready flag.
    output logic            chan_pwr_dn,    // Channel blocks powered down.
    output logic            cdr_locked,     // Lock indication.
    output logic [1:0]      conf_chk_cnt    // Confirmation checks done.
);

    function automatic logic [8:0] scale_tol(input logic [7:0] base, input logic [1:0] sel);
        logic [8:0] tmp;
        tmp = sel[1] ? {base, 1'b0} : {1'b0, base};
        if (sel[0])
        begin
            tmp = tmp + {6'h00, base[3:1]};
        end
        return tmp;
    endfunction : scale_tol

    // Two-stage synchronisers; the first stage feeds only the second.
    logic sd_meta;
    logic sd_sync;
    logic lk_meta;
    logic lk_sync;

    logic       inhib;
    logic [1:0] conf_cnt;
    logic [3:0] rsvd_a;
    logic [1:0] scale_sel;
    logic       cap_req;
    logic [4:0] rsvd_b;
    logic [31:0] pd_cnt;
    logic [7:0]  chk_tmr;
    logic        check_tick;

    logic        next_inhib;
    logic [1:0]  next_conf_cnt;
    logic [3:0]  next_rsvd_a;
    logic [1:0]  next_scale_sel;
    logic        next_cap_req;
    logic [4:0]  next_rsvd_b;
    logic [7:0]  next_reg_rdata;
    logic [31:0] next_pd_cnt;
    logic        next_chan_pwr_dn;
    logic [7:0]  next_chk_tmr;
    logic        next_check_tick;
    clm_ppm_res_t next_ppm_res;
    logic        cap_done;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
            lk_meta <= 1'b0;
            lk_sync <= 1'b0;
        end
        else
        begin
            sd_meta <= sig_det;
            sd_sync <= sd_meta;
            lk_meta <= lock_crit;
            lk_sync <= lk_meta;
        end
    end

    // Register file, read port and capture request.
    always_comb
    begin
        next_inhib     = inhib;
        next_conf_cnt  = conf_cnt;
        next_rsvd_a    = rsvd_a;
        next_scale_sel = scale_sel;
        next_cap_req   = cap_req;
        next_rsvd_b    = rsvd_b;
        next_reg_rdata = reg_rdata;
        if (cap_done)
        begin
            next_cap_req = 1'b0;
        end
        if (reg_wr && reg_addr == `CLM_ADDR_PWR_LOCK)
        begin
            next_inhib    = reg_wdata[`CLM_BIT_INHIB];
            next_conf_cnt = reg_wdata[`CLM_BIT_CONF_HI:`CLM_BIT_CONF_LO];
            next_rsvd_a   = reg_wdata[`CLM_RSVD_HI:`CLM_RSVD_LO];
        end
        if (reg_wr && reg_addr == `CLM_ADDR_PPM_TOL)
        begin
            next_scale_sel = reg_wdata[`CLM_BIT_SCALE_HI:`CLM_BIT_SCALE_LO];
            next_rsvd_b    = reg_wdata[`CLM_PPM_RSVD_HI:`CLM_RSVD_LO];
            // A fresh request wins over a capture finishing in the same cycle.
            if (reg_wdata[`CLM_BIT_CAPTURE])
            begin
                next_cap_req = 1'b1;
            end
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `CLM_ADDR_PWR_LOCK: next_reg_rdata = {ppm_res.rdy, inhib, conf_cnt, rsvd_a};
                `CLM_ADDR_PPM_TOL:  next_reg_rdata = {scale_sel, cap_req, rsvd_b};
                default:            next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            inhib     <= 1'b0;
            conf_cnt  <= 2'h3;
            rsvd_a    <= 4'hF;
            scale_sel <= 2'h0;
            cap_req   <= 1'b0;
            rsvd_b    <= 5'h1F;
            reg_rdata <= 8'h00;
        end
        else
        begin
            inhib     <= next_inhib;
            conf_cnt  <= next_conf_cnt;
            rsvd_a    <= next_rsvd_a;
            scale_sel <= next_scale_sel;
            cap_req   <= next_cap_req;
            rsvd_b    <= next_rsvd_b;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Idle power-down timer, lock check pacing and tolerance scaling.
    always_comb
    begin
        next_pd_cnt      = pd_cnt;
        next_chan_pwr_dn = chan_pwr_dn;
        if (inhib || sd_sync)
        begin
            next_pd_cnt      = 32'h0;
            next_chan_pwr_dn = 1'b0;
        end
        else if (pd_cnt >= 32'(PD_CYCLES - 1))
        begin
            next_chan_pwr_dn = 1'b1;
        end
        else
        begin
            next_pd_cnt = pd_cnt + 32'h1;
        end
        next_check_tick = (chk_tmr == 8'h00);
        next_chk_tmr    = next_check_tick ? `CLM_CHK_CYCLES - 8'h01 : chk_tmr - 8'h01;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pd_cnt        <= 32'h0;
            chan_pwr_dn   <= 1'b0;
            chk_tmr       <= 8'h00;
            check_tick    <= 1'b0;
            ppm_delta_eff <= 9'h000;
        end
        else
        begin
            pd_cnt        <= next_pd_cnt;
            chan_pwr_dn   <= next_chan_pwr_dn;
            chk_tmr       <= next_chk_tmr;
            check_tick    <= next_check_tick;
            ppm_delta_eff <= scale_tol(ppm_delta_base, scale_sel);
        end
    end

    // Lock checks keep running; while the channel is powered down they always fail.
    clm_lock_confirm clm_lock_confirm_inst
    (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .check_tick (check_tick),
        .crit_ok    (lk_sync && !chan_pwr_dn),
        .conf_cnt   (conf_cnt),
        .locked     (cdr_locked),
        .chk_cnt    (conf_chk_cnt)
    );

    // Ppm result: refreshed freely while nobody holds it, forced by a capture request.
    assign cap_done = cap_req && ppm_count_vld;

    always_comb
    begin
        next_ppm_res = ppm_res;
        if (ppm_res_read)
        begin
            next_ppm_res.rdy = 1'b0;
        end
        if (cap_done || (ppm_count_vld && !ppm_res.rdy))
        begin
            next_ppm_res.val = ppm_count;
            next_ppm_res.rdy = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ppm_res <= '0;
        end
        else
        begin
            ppm_res <= next_ppm_res;
        end
    end

    a_pd_inhibit: assert property (@(posedge clk_sys) disable iff (!rstn)
        inhib |=> !chan_pwr_dn)
        else $error("Channel powered down while inhibit set.");

    a_pd_timeout: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(chan_pwr_dn) |-> $past(pd_cnt) == 32'(PD_CYCLES - 1) && !$past(sd_sync))
        else $error("Power-down not at end of idle time.");

    a_pd_sigdet: assert property (@(posedge clk_sys) disable iff (!rstn)
        sd_sync |=> !chan_pwr_dn ##1 !chan_pwr_dn)
        else $error("Channel down while signal detected.");

    a_tol_double: assert property (@(posedge clk_sys) disable iff (!rstn)
        scale_sel == 2'h3
        |=> ppm_delta_eff == {1'b0, $past(ppm_delta_base)} + {1'b0, $past(ppm_delta_base)}
            + {6'h00, $past(ppm_delta_base[3:1])})
        else $error("Scaled tolerance wrong.");

    a_cap_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        cap_req && ppm_count_vld && !reg_wr
        |=> !cap_req && ppm_res.rdy && ppm_res.val == $past(ppm_count))
        else $error("Capture request did not complete.");

    a_free_update: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ppm_res.rdy && ppm_count_vld |=> ppm_res.rdy && ppm_res.val == $past(ppm_count))
        else $error("Free-running ppm update missed.");

    a_ready_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(ppm_res.rdy) |-> $past(ppm_count_vld))
        else $error("Ready flag set without a tally result.");

    a_result_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        ppm_res.rdy && !cap_req |=> $stable(ppm_res.val))
        else $error("Ppm result changed while ready.");

endmodule : clm_monitor

// file: verilog/clm_defs.svh
// Register offsets, field positions, reset values and timing counts of the lock monitor.
// Included by every design module, not by the package; definitions only.
`ifndef CLM_DEFS_SVH
`define CLM_DEFS_SVH

`define CLM_ADDR_PWR_LOCK   8'h34
`define CLM_ADDR_PPM_TOL    8'h35

`define CLM_PWR_LOCK_RST    8'h3F
`define CLM_PPM_TOL_RST     8'h1F

`define CLM_BIT_RDY         7
`define CLM_BIT_INHIB       6
`define CLM_BIT_CONF_HI     5
`define CLM_BIT_CONF_LO     4
`define CLM_BIT_SCALE_HI    7
`define CLM_BIT_SCALE_LO    6
`define CLM_BIT_CAPTURE     5
`define CLM_RSVD_HI         3
`define CLM_RSVD_LO         0
`define CLM_PPM_RSVD_HI     4

`define CLM_CLK_MHZ         125
`define CLM_PD_TIME_MS      100
`define CLM_PD_CYCLES       (`CLM_PD_TIME_MS * `CLM_CLK_MHZ * 1000)

`define CLM_CHK_CYCLES      8'h10

`endif

// file: verilog/clm_pkg.sv
// Types shared by the lock monitor modules.
// Numbers live in clm_defs.svh; this package holds only types.
package clm_pkg;

    typedef enum logic [1:0]
    {
        CLM_UNLOCKED = 2'h0,
        CLM_LOCKED   = 2'h1,
        CLM_CONFIRM  = 2'h3
    } clm_lock_st_t;

    typedef struct packed
    {
        logic        rdy;
        logic [15:0] val;
    } clm_ppm_res_t;

endpackage : clm_pkg

// file: verilog/clm_lock_confirm.sv
// Lock tracking with loss confirmation for one recovery channel.
// Assumes crit_ok is already synchronised and check_tick is a one-cycle pulse.
`timescale 1ns/100ps
`include "clm_defs.svh"

module clm_lock_confirm
    import clm_pkg::*;
(
    input  wire logic       clk_sys,     // Core clock.
    input  wire logic       rstn,        // Asynchronous reset, active low.
    input  wire logic       check_tick,  // One lock check per pulse.
    input  wire logic       crit_ok,     // Lock criteria met.
    input  wire logic [1:0] conf_cnt,    // Extra checks before loss.
    output logic            locked,      // Lock indication.
    output logic [1:0]      chk_cnt      // Confirmation checks done.
);

    clm_lock_st_t state;
    clm_lock_st_t next_state;
    logic [1:0]   next_chk_cnt;

    always_comb
    begin
        next_state   = state;
        next_chk_cnt = chk_cnt;
        if (check_tick)
        begin
            case (state)
                CLM_UNLOCKED:
                begin
                    if (crit_ok)
                    begin
                        next_state = CLM_LOCKED;
                    end
                end
                CLM_LOCKED:
                begin
                    next_chk_cnt = 2'h0;
                    if (!crit_ok)
                    begin
                        next_state = (conf_cnt == 2'h0) ? CLM_UNLOCKED : CLM_CONFIRM;
                    end
                end
                CLM_CONFIRM:
                begin
                    if (crit_ok)
                    begin
                        next_state   = CLM_LOCKED;
                        next_chk_cnt = 2'h0;
                    end
                    else if (chk_cnt + 2'h1 >= conf_cnt)
                    begin
                        next_state   = CLM_UNLOCKED;
                        next_chk_cnt = 2'h0;
                    end
                    else
                    begin
                        next_chk_cnt = chk_cnt + 2'h1;
                    end
                end
                default:
                begin
                    next_state   = CLM_UNLOCKED;
                    next_chk_cnt = 2'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state   <= CLM_UNLOCKED;
            chk_cnt <= 2'h0;
            locked  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            chk_cnt <= next_chk_cnt;
            locked  <= (next_state != CLM_UNLOCKED);
        end
    end

    a_loss_after_count: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == CLM_CONFIRM && check_tick && !crit_ok && chk_cnt + 2'h1 >= conf_cnt
        |=> !locked && state == CLM_UNLOCKED)
        else $error("Lock not dropped after last confirmation check.");

    a_confirm_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == CLM_LOCKED && check_tick && !crit_ok && conf_cnt != 2'h0
        |=> locked && state == CLM_CONFIRM)
        else $error("Lock dropped before confirmation checks ran.");

    a_regain_reset: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == CLM_CONFIRM && check_tick && crit_ok
        |=> locked && chk_cnt == 2'h0 && state == CLM_LOCKED)
        else $error("Regained lock did not clear the confirmation count.");

endmodule : clm_lock_confirm

// file: bench/clm_monitor_bench.sv
// Self-checking bench for the per-channel lock monitor.
// Drives the register port and status inputs directly; power-down count shortened to 20.
`timescale 1ns/100ps

module clm_monitor_bench;
    import clm_pkg::*;

    localparam int PD    = 20;
    localparam int LIMIT = 6000;

    logic         clk_sys;
    logic         rstn;
    logic         reg_wr;
    logic         reg_rd;
    logic [7:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic [7:0]   reg_rdata;
    logic         sig_det;
    logic         lock_crit;
    logic [7:0]   ppm_delta_base;
    logic [8:0]   ppm_delta_eff;
    logic [15:0]  ppm_count;
    logic         ppm_count_vld;
    logic         ppm_res_read;
    clm_ppm_res_t ppm_res;
    logic         chan_pwr_dn;
    logic         cdr_locked;
    logic [1:0]   conf_chk_cnt;
    int           n_fail;
    int           check_count;
    int           cycles;
    logic [8:0]   eff_exp [4];

    clm_monitor #(.PD_CYCLES(PD)) clm_monitor_inst
    (
        .clk_sys        (clk_sys),
        .rstn           (rstn),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_rdata      (reg_rdata),
        .sig_det        (sig_det),
        .lock_crit      (lock_crit),
        .ppm_delta_base (ppm_delta_base),
        .ppm_delta_eff  (ppm_delta_eff),
        .ppm_count      (ppm_count),
        .ppm_count_vld  (ppm_count_vld),
        .ppm_res_read   (ppm_res_read),
        .ppm_res        (ppm_res),
        .chan_pwr_dn    (chan_pwr_dn),
        .cdr_locked     (cdr_locked),
        .conf_chk_cnt   (conf_chk_cnt)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    // Result becomes visible on the edge that takes the pulse.
    task automatic pulse(input logic [15:0] v);
        @(posedge clk_sys);
        ppm_count_vld <= 1'b1;
        ppm_count     <= v;
        @(posedge clk_sys);
        ppm_count_vld <= 1'b0;
        @(negedge clk_sys);
    endtask : pulse

    initial
    begin : main
        int  c;
        bit  dropped;
        logic [1:0] mx;
        eff_exp = '{9'h0AB, 9'h0B0, 9'h156, 9'h15B};
        cycles = 0;
        n_fail = 0;
        check_count = 0;
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sig_det = 1'b1;
        lock_crit = 1'b1;
        ppm_delta_base = 8'hAB;
        ppm_count = 16'h0000;
        ppm_count_vld = 1'b0;
        ppm_res_read = 1'b0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(8'h34, 8'h3F);
        rd(8'h35, 8'h1F);
        wr(8'h36, 8'h55);
        rd(8'h36, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h35, {s[1:0], 6'h1F});
            repeat (3) @(negedge clk_sys);
            check({7'h00, ppm_delta_eff}, {7'h00, eff_exp[s]});
        end
        pulse(16'h1234);
        check(ppm_res.val, 16'h1234);
        check({15'h0, ppm_res.rdy}, 16'h1);
        rd(8'h34, 8'hBF);
        pulse(16'h5678);
        check(ppm_res.val, 16'h1234);
        wr(8'h35, 8'hFF);
        rd(8'h35, 8'hFF);
        pulse(16'hBEEF);
        check(ppm_res.val, 16'hBEEF);
        rd(8'h35, 8'hDF);
        @(posedge clk_sys);
        ppm_res_read <= 1'b1;
        @(posedge clk_sys);
        ppm_res_read <= 1'b0;
        @(negedge clk_sys);
        check({15'h0, ppm_res.rdy}, 16'h0);
        wr(8'h34, 8'hB0);
        rd(8'h34, 8'h30);
        pulse(16'h0042);
        check(ppm_res.val, 16'h0042);
        // Each drop must land after the N confirmation ticks but before one more.
        for (int n = 0; n < 4; n++)
        begin
            wr(8'h34, {2'b00, n[1:0], 4'hF});
            c = 0;
            while (!cdr_locked && c < 60)
            begin
                @(negedge clk_sys);
                c++;
            end
            @(posedge clk_sys);
            lock_crit <= 1'b0;
            c = 0;
            while (cdr_locked && c < 120)
            begin
                @(negedge clk_sys);
                c++;
            end
            check({15'h0, c >= n * 16 + 4 && c <= n * 16 + 19}, 16'h1);
            @(posedge clk_sys);
            lock_crit <= 1'b1;
            repeat (40) @(negedge clk_sys);
            check({15'h0, cdr_locked}, 16'h1);
        end
        dropped = 1'b0;
        mx = 2'h0;
        @(posedge clk_sys);
        lock_crit <= 1'b0;
        repeat (36)
        begin
            @(negedge clk_sys);
            dropped |= !cdr_locked;
            if (conf_chk_cnt > mx)
                mx = conf_chk_cnt;
        end
        @(posedge clk_sys);
        lock_crit <= 1'b1;
        repeat (40)
        begin
            @(negedge clk_sys);
            dropped |= !cdr_locked;
        end
        check({15'h0, dropped}, 16'h0);
        check({15'h0, mx != 2'h0}, 16'h1);
        check({14'h0, conf_chk_cnt}, 16'h0);
        wr(8'h34, 8'h0F);
        @(posedge clk_sys);
        sig_det <= 1'b0;
        c = 0;
        while (!chan_pwr_dn && c < 100)
        begin
            @(negedge clk_sys);
            c++;
        end
        check({15'h0, c >= PD && c <= PD + 5}, 16'h1);
        @(posedge clk_sys);
        sig_det <= 1'b1;
        repeat (5) @(negedge clk_sys);
        check({15'h0, chan_pwr_dn}, 16'h0);
        wr(8'h34, 8'h4F);
        @(posedge clk_sys);
        sig_det <= 1'b0;
        dropped = 1'b0;
        repeat (3 * PD)
        begin
            @(negedge clk_sys);
            dropped |= chan_pwr_dn;
        end
        check({15'h0, dropped}, 16'h0);
        test_done();
    end

endmodule : clm_monitor_bench
